// file: core/slbs_defs.svh
// constants of the status led blink sequencer: offsets, fields, timing
`ifndef SLBS_DEFS_SVH
`define SLBS_DEFS_SVH

// module clock rate in kHz (10 MHz)
`define SLBS_CLK_KHZ 10000

// pattern times in ms
`define SLBS_UNIT_MS 200
`define SLBS_SLOW_MS 1600
`define SLBS_GAP_MS 1000
`define SLBS_REG_MS 10000

// register byte offsets
`define SLBS_ADDR_CTRL 12'h000
`define SLBS_ADDR_FAULT 12'h004
`define SLBS_ADDR_STAT 12'h008

// control register fields
`define SLBS_CTRL_POWER 0
`define SLBS_CTRL_DEMAND 1
`define SLBS_CTRL_SETUP 2
`define SLBS_CTRL_W 3

// fault register fields, bit i gives an (i+1)-pulse group
`define SLBS_FAULT_DUPADDR 0
`define SLBS_FAULT_BUSERR 1
`define SLBS_FAULT_UNKNOWN 2
`define SLBS_FAULT_OVERCUR 3
`define SLBS_FAULT_OPEN 4
`define SLBS_FAULT_W 5

// status register fields
`define SLBS_STAT_MODE_LSB 0
`define SLBS_STAT_CODE_LSB 5
`define SLBS_STAT_LED 8
`define SLBS_STAT_REGDONE 9

// reset values
`define SLBS_CTRL_RST 3'h0
`define SLBS_FAULT_RST 5'h00

`endif

// file: core/slbs_pkg.sv
// types shared by the status led blink sequencer modules
`default_nettype none

package slbs_pkg;

    // displayed mode, one-hot
    typedef enum logic [4:0] {
        ST_OFF  = 5'h01,
        ST_REG  = 5'h02,
        ST_IDLE = 5'h04,
        ST_FAST = 5'h08,
        ST_ERR  = 5'h10
    } slbs_mode_e;

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } slbs_tick_s;

    typedef struct packed {
        slbs_mode_e mode;
        logic [2:0] code;
        logic [3:0] ph;
        logic led;
        logic [5:0] reg_cnt;
        logic reg_done;
        logic [2:0] ctrl;
        logic [4:0] fault;
        logic [31:0] prdata;
    } slbs_top_s;

endpackage

`default_nettype wire

// file: core/slbs_tick.sv
// tick generator: one pulse per pattern unit, restartable
`timescale 1ns/1ps
`default_nettype none

module slbs_tick
    import slbs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 2000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // tick link
    slbs_tick_if.gen tb
);

    localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

    slbs_tick_s s_q;
    slbs_tick_s s_d;

    always_comb begin
        s_d = s_q;
        // a restart aligns the first tick one full unit after it
        if (tb.restart || s_q.cnt == LAST) begin
            s_d.cnt = 32'h0000_0000;
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
        s_d.tick = !tb.restart && (s_q.cnt == LAST);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tb.tick = s_q.tick;

endmodule // slbs_tick

`default_nettype wire

// file: core/slbs_tick_if.sv
// tick request and tick pulse between sequencer and tick generator
`timescale 1ns/1ps
`default_nettype none

interface slbs_tick_if;
    logic restart;
    logic tick;

    modport gen (input restart, output tick);
    modport user (output restart, input tick);
endinterface

`default_nettype wire

// file: core/slbs_top.sv
// status led blink sequencer with apb registers
// Function
// - led fully dark whenever the system is powered down.
// - after start-up, led steady on for about 10 s during registration.
// - ready and idle: repeat 1.6 s on, 1.6 s off.
// - demand data arriving: repeat 0.2 s on, 0.2 s off.
// - setup screens or editor return the led to the slow blink.
// - error: N pulses 0.2 s on / 0.2 s off, then 1 s off, repeated.
// - one pulse for two devices sharing one network address.
// - two pulses for too many network bus errors.
// - three pulses for a component of unknown type.
// - four pulses while the valve over-current trip is active.
// - five pulses for an open circuit on a steer valve output.
`timescale 1ns/1ps
`default_nettype none
`include "slbs_defs.svh"

module slbs_top
    import slbs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `SLBS_UNIT_MS * `SLBS_CLK_KHZ
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // status led
    output logic LED_ON
);

    // pattern lengths in ticks of one unit
    localparam logic [3:0] SLOW_T = 4'(`SLBS_SLOW_MS / `SLBS_UNIT_MS);
    localparam logic [3:0] GAP_T = 4'(`SLBS_GAP_MS / `SLBS_UNIT_MS);
    localparam logic [5:0] REG_T = 6'(`SLBS_REG_MS / `SLBS_UNIT_MS);

    slbs_top_s s_q;
    slbs_top_s s_d;
    slbs_tick_if tick_bus ();

    logic tk;
    logic mapped;
    logic wr_en;
    logic chg;
    logic [31:0] rd_word;
    slbs_mode_e mode_d;
    logic [2:0] code_d;

    slbs_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(SYS_CLK),
        .rst(RST),
        .tb(tick_bus)
    );

    assign tk = tick_bus.tick;

    // cycle length of a pattern in ticks
    function automatic logic [3:0] period_of(slbs_mode_e m, logic [2:0] c);
        logic [3:0] p;
        p = 4'h1;
        unique case (m)
            ST_IDLE: p = 4'(2 * SLOW_T); // 16 wraps to 0, p - 1 is 15
            ST_FAST: p = 4'h2;
            ST_ERR: p = {c, 1'b0} - 4'h1 + GAP_T;
            ST_OFF, ST_REG: p = 4'h1;
            default: p = 4'h1;
        endcase
        return p;
    endfunction

    // led level for a mode at a given phase
    function automatic logic led_of(slbs_mode_e m, logic [2:0] c,
                                    logic [3:0] ph);
        logic l;
        l = 1'b0;
        unique case (m)
            ST_OFF: l = 1'b0;
            ST_REG: l = 1'b1;
            ST_IDLE: l = (ph < SLOW_T);
            ST_FAST: l = (ph == 4'h0);
            ST_ERR: l = (ph < ({c, 1'b0} - 4'h1)) && !ph[0];
            default: l = 1'b0;
        endcase
        return l;
    endfunction

    // apb decode
    assign mapped = (PADDR == `SLBS_ADDR_CTRL) ||
                    (PADDR == `SLBS_ADDR_FAULT) ||
                    (PADDR == `SLBS_ADDR_STAT);
    assign wr_en = PSEL && PENABLE && PWRITE && PSTRB[0];
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = s_q.prdata;
    assign LED_ON = s_q.led;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (PADDR)
            `SLBS_ADDR_CTRL: rd_word[`SLBS_CTRL_W-1:0] = s_q.ctrl;
            `SLBS_ADDR_FAULT: rd_word[`SLBS_FAULT_W-1:0] = s_q.fault;
            `SLBS_ADDR_STAT: begin
                rd_word[`SLBS_STAT_MODE_LSB +: 5] = s_q.mode;
                rd_word[`SLBS_STAT_CODE_LSB +: 3] = s_q.code;
                rd_word[`SLBS_STAT_LED] = s_q.led;
                rd_word[`SLBS_STAT_REGDONE] = s_q.reg_done;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // displayed mode and error group selection
    always_comb begin
        code_d = 3'h0;
        // highest bit first so the lowest set bit wins
        for (int i = `SLBS_FAULT_W - 1; i >= 0; i--) begin
            if (s_q.fault[i]) begin
                code_d = 3'(i + 1);
            end
        end
        if (!s_q.ctrl[`SLBS_CTRL_POWER]) begin
            mode_d = ST_OFF;
            code_d = 3'h0;
        end else if (s_q.fault != 5'h00) begin
            mode_d = ST_ERR;
        end else if (!s_q.reg_done) begin
            mode_d = ST_REG;
        end else if (s_q.ctrl[`SLBS_CTRL_DEMAND] &&
                     !s_q.ctrl[`SLBS_CTRL_SETUP]) begin
            mode_d = ST_FAST;
        end else begin
            mode_d = ST_IDLE;
        end
        chg = (mode_d != s_q.mode) || (code_d != s_q.code);
    end

    assign tick_bus.restart = chg;

    always_comb begin
        s_d = s_q;
        // read data is captured in the setup phase, so no wait states
        if (PSEL && !PENABLE) begin
            s_d.prdata = rd_word;
        end
        if (wr_en) begin
            if (PADDR == `SLBS_ADDR_CTRL) begin
                s_d.ctrl = PWDATA[`SLBS_CTRL_W-1:0];
            end
            if (PADDR == `SLBS_ADDR_FAULT) begin
                s_d.fault = PWDATA[`SLBS_FAULT_W-1:0];
            end
        end
        s_d.mode = mode_d;
        s_d.code = code_d;
        // registration window restarts at every power-up
        if (mode_d == ST_OFF) begin
            s_d.reg_cnt = 6'h00;
            s_d.reg_done = 1'b0;
        end else if (s_q.mode == ST_REG && mode_d == ST_REG && tk) begin
            if (s_q.reg_cnt == REG_T - 6'h01) begin
                s_d.reg_done = 1'b1;
            end else begin
                s_d.reg_cnt = s_q.reg_cnt + 6'h01;
            end
        end
        if (chg) begin
            s_d.ph = 4'h0;
        end else if (tk) begin
            if (s_q.ph >= period_of(s_q.mode, s_q.code) - 4'h1) begin
                s_d.ph = 4'h0;
            end else begin
                s_d.ph = s_q.ph + 4'h1;
            end
        end
        s_d.led = led_of(s_d.mode, s_d.code, s_d.ph);
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
            s_q.mode <= ST_OFF;
            s_q.ctrl <= `SLBS_CTRL_RST;
            s_q.fault <= `SLBS_FAULT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    logic pw_q;
    logic nf_q;
    assign pw_q = s_q.ctrl[`SLBS_CTRL_POWER];
    assign nf_q = (s_q.fault == 5'h00);

    a_dark_powerdown: assert property (
        !pw_q |=> !LED_ON && s_q.mode == ST_OFF)
        else $error("led not dark while powered down");

    a_reg_solid: assert property (
        s_q.mode == ST_REG |-> LED_ON)
        else $error("led not steady during registration");

    a_reg_length: assert property (
        (s_q.mode == ST_REG && tk && s_q.reg_cnt == REG_T - 6'h01 &&
         pw_q && nf_q) |=> s_q.reg_done ##1 s_q.mode != ST_REG)
        else $error("registration window wrong length");

    a_slow_shape: assert property (
        s_q.mode == ST_IDLE |-> LED_ON == (s_q.ph < SLOW_T))
        else $error("slow blink shape wrong");

    a_fast_select: assert property (
        (pw_q && nf_q && s_q.reg_done &&
         s_q.ctrl[`SLBS_CTRL_DEMAND] && !s_q.ctrl[`SLBS_CTRL_SETUP])
        |=> s_q.mode == ST_FAST && LED_ON == (s_q.ph == 4'h0))
        else $error("fast blink not shown on demand");

    a_setup_slow: assert property (
        (pw_q && nf_q && s_q.reg_done && s_q.ctrl[`SLBS_CTRL_SETUP])
        |=> s_q.mode == ST_IDLE)
        else $error("setup screen did not give slow blink");

    a_err_shape: assert property (
        s_q.mode == ST_ERR |-> LED_ON ==
        ((s_q.ph < ({s_q.code, 1'b0} - 4'h1)) && !s_q.ph[0]))
        else $error("error group shape wrong");

    a_err_wrap: assert property (
        (s_q.mode == ST_ERR && tk && !chg &&
         s_q.ph == {s_q.code, 1'b0} + GAP_T - 4'h2)
        |=> s_q.ph == 4'h0 && LED_ON)
        else $error("error group does not repeat");

    a_err_lowest: assert property (
        (pw_q && s_q.fault[0]) |=> s_q.mode == ST_ERR && s_q.code == 3'h1)
        else $error("lowest fault not shown");

    a_err_open: assert property (
        (pw_q && s_q.fault == 5'h10) |=> s_q.code == 3'h5)
        else $error("open circuit code wrong");

    a_err_overcur: assert property (
        (pw_q && s_q.fault[4:3] != 2'b00 && s_q.fault[2:0] == 3'h0 &&
         s_q.fault[3]) |=> s_q.code == 3'h4)
        else $error("over-current code wrong");

    a_change_restart: assert property (
        chg |=> s_q.ph == 4'h0 ##1 (s_q.ph == 4'h0 || $past(tk)))
        else $error("pattern not restarted on change");

    a_idle_wrap: assert property (
        (s_q.mode == ST_IDLE && tk && !chg && s_q.ph == 4'hF)
        |=> s_q.ph == 4'h0 && LED_ON)
        else $error("slow blink does not repeat after 16 units");

    a_idle_half: assert property (
        (s_q.mode == ST_IDLE && tk && !chg && s_q.ph == 4'h7)
        |=> s_q.ph == 4'h8 && !LED_ON)
        else $error("slow blink lit half wrong length");

    a_fast_toggle: assert property (
        (s_q.mode == ST_FAST && tk && !chg) |=> LED_ON != $past(LED_ON))
        else $error("fast blink does not toggle each unit");

    a_restart_quiet: assert property (
        chg |=> !tk)
        else $error("tick not restarted with the pattern");

    a_off_clears: assert property (
        s_q.mode == ST_OFF |-> !s_q.reg_done && s_q.reg_cnt == 6'h00)
        else $error("registration not restarted after power down");

    a_ctrl_write: assert property (
        (wr_en && PADDR == `SLBS_ADDR_CTRL)
        |=> s_q.ctrl == $past(PWDATA[`SLBS_CTRL_W-1:0]))
        else $error("control write not stored");

    a_fault_write: assert property (
        (wr_en && PADDR == `SLBS_ADDR_FAULT)
        |=> s_q.fault == $past(PWDATA[`SLBS_FAULT_W-1:0]))
        else $error("fault write not stored");

    c_idle_blink: cover property (
        s_q.mode == ST_IDLE && $fell(LED_ON));
    c_fast_blink: cover property (
        s_q.mode == ST_FAST && $rose(LED_ON));
    c_err_five: cover property (
        s_q.mode == ST_ERR && s_q.code == 3'h5 && s_q.ph == 4'h8);
    c_reg_done: cover property ($rose(s_q.reg_done));
    c_err_single: cover property (
        s_q.mode == ST_ERR && s_q.code == 3'h1 && $rose(LED_ON));

endmodule // slbs_top

`default_nettype wire

// file: tb/slbs_led_obs.sv
// led observer: lengths of lit, dark and gap runs and pulses per group
`timescale 1ns/1ps
`default_nettype none

module slbs_led_obs #(
    parameter int GAP = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched led
    input wire logic led,
    // measured runs in clocks, and pulses in the last group
    output int on_len,
    output int off_len,
    output int gap_len,
    output int grp
);
    int run;
    int cnt;
    logic led_q;

    // a dark run longer than GAP closes a pulse group
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {on_len, off_len, gap_len, grp, run, cnt} <= '0;
            led_q <= 1'b0;
        end else begin
            led_q <= led;
            if (led !== led_q) begin
                run <= 1;
                if (led_q) begin
                    on_len <= run;
                end else if (run > GAP) begin
                    gap_len <= run;
                    off_len <= run;
                    grp <= cnt;
                    cnt <= 1;
                end else begin
                    off_len <= run;
                    cnt <= cnt + 1;
                end
            end else begin
                run <= run + 1;
            end
        end
    end
endmodule // slbs_led_obs

`default_nettype wire

// file: tb/slbs_top_tb_top.sv
// testbench of the status led blink sequencer
`timescale 1ns/1ps
`default_nettype none

module slbs_top_tb_top;
    localparam int T = 4;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [3:0] pst = 4'hF;
    logic prdy, perr, led, err_q;
    int errors = 0, n_tests = 0, on_len, off_len, gap_len, grp, i, n;

    always #50 clk = ~clk;

    slbs_top #(.TICK_CYCLES(T)) dut (.SYS_CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PSTRB(pst), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .LED_ON(led));

    slbs_led_obs #(.GAP(2 * T)) obs (.clk(clk), .rst(rst), .led(led),
        .on_len(on_len), .off_len(off_len), .gap_len(gap_len),
        .grp(grp));

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (prdy === 1'b1) break;
        end
        if (k == 20) begin
            errors++;
            finish_test();
        end
        rd = prd;
        err_q = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_rst;
        apb(0, 12'h008, 0);
        chk("off mode", rd[4:0], 5'h01);
        chk("off led", led, 1'b0);
        chk("no slverr", err_q, 1'b0);
        apb(0, 12'h00C, 0);
        chk("slverr", err_q, 1'b1);
        chk("unmapped", rd, 32'h0);
        apb(1, 12'h008, 32'hFF);
        pst <= 4'h0;
        apb(1, 12'h000, 32'h1);
        pst <= 4'hF;
        apb(0, 12'h000, 0);
        chk("ctrl", rd, 32'h0);
        apb(0, 12'h008, 0);
        chk("stat ro", rd[4:0], 5'h01);
        $display("test reset ended");
    endtask

    task automatic t_reg;
        apb(1, 12'h000, 32'h1);
        wt(2);
        chk("reg led", led, 1'b1);
        apb(0, 12'h008, 0);
        chk("reg mode", rd[4:0], 5'h02);
        chk("reg stat led", rd[8], 1'b1);
        for (i = 0; i < 700 && led === 1'b1; i++) @(negedge clk);
        chk("reg span", i >= 58 * T - 12 && i <= 58 * T + 4, 1);
        apb(0, 12'h008, 0);
        chk("idle mode", rd[4:0], 5'h04);
        chk("reg done", rd[9], 1'b1);
        wt(48 * T);
        chk("idle on", on_len, 8 * T);
        chk("idle off", off_len, 8 * T);
        $display("test registration ended");
    endtask

    task automatic t_fast;
        apb(1, 12'h000, 32'h3);
        wt(6 * T);
        apb(0, 12'h008, 0);
        chk("fast mode", rd[4:0], 5'h08);
        chk("fast on", on_len, T);
        chk("fast off", off_len, T);
        apb(1, 12'h000, 32'h7);
        wt(40 * T);
        chk("setup on", on_len, 8 * T);
        chk("setup off", off_len, 8 * T);
        apb(0, 12'h008, 0);
        chk("setup mode", rd[4:0], 5'h04);
        apb(1, 12'h000, 32'h3);
        $display("test fast ended");
    endtask

    task automatic t_err;
        for (n = 1; n <= 5; n++) begin
            apb(1, 12'h004, 32'h1 << (n - 1));
            wt(3 * (2 * n + 4) * T);
            apb(0, 12'h008, 0);
            chk("err mode", rd[4:0], 5'h10);
            chk("err code", rd[7:5], n);
            chk("err pulses", grp, n);
            chk("err on", on_len, T);
            chk("err gap", gap_len, 5 * T);
        end
        $display("test errors ended");
    endtask

    task automatic t_prio;
        int hi;
        apb(1, 12'h004, 32'h1C);
        wt(30 * T);
        apb(0, 12'h008, 0);
        chk("prio code", rd[7:5], 3'h3);
        chk("prio pulses", grp, 3);
        apb(0, 12'h004, 0);
        chk("fault reg", rd, 32'h1C);
        apb(1, 12'h000, 32'h0);
        wt(1);
        hi = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (led !== 1'b0) hi++;
        end
        chk("dark with fault", hi, 0);
        apb(1, 12'h004, 32'h0);
        $display("test priority ended");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_rst();
        t_reg();
        t_fast();
        t_err();
        t_prio();
        finish_test();
    end
endmodule // slbs_top_tb_top

`default_nettype wire
